// file: pkg/virs_pkg.sv
package virs_pkg;

  localparam int unsigned VIRS_DW = 32;
  localparam int unsigned VIRS_AW = 32;
  localparam int unsigned VIRS_NSRC = 32;
  localparam int unsigned VIRS_NSLOT = 16;
  localparam int unsigned VIRS_SRC_W = 5;
  localparam int unsigned VIRS_SLOT_W = 4;
  localparam int unsigned VIRS_NEVT = 2;

  // Register byte addresses.
  localparam logic [31:0] VIRS_ADDR_REQUEST_ENABLE = 32'hFFFFF010;
  localparam logic [31:0] VIRS_ADDR_ENABLE_CLEAR = 32'hFFFFF014;
  localparam logic [31:0] VIRS_ADDR_SOFTWARE_REQUEST = 32'hFFFFF018;
  localparam logic [31:0] VIRS_ADDR_SOFTWARE_REQUEST_CLEAR = 32'hFFFFF01C;
  localparam logic [31:0] VIRS_ADDR_PRIVILEGE_GUARD = 32'hFFFFF020;
  localparam logic [31:0] VIRS_ADDR_CURRENT_VECTOR = 32'hFFFFF030;
  localparam logic [31:0] VIRS_ADDR_DEFAULT_VECTOR = 32'hFFFFF034;
  localparam logic [31:0] VIRS_ADDR_EVENT_STATUS = 32'hFFFFF040;
  localparam logic [31:0] VIRS_ADDR_EVENT_MASK = 32'hFFFFF044;
  localparam logic [31:0] VIRS_ADDR_SLOT_VECTOR_BASE = 32'hFFFFF100;
  localparam logic [31:0] VIRS_ADDR_SLOT_CONTROL_BASE = 32'hFFFFF200;

  // A slot array occupies 16 words; the low six address bits select within it.
  localparam int unsigned VIRS_SLOT_REGION_LSB = 6;
  localparam int unsigned VIRS_SLOT_IDX_LSB = 2;

  // Slot control layout: source number in the low bits, enable above it.
  localparam int unsigned VIRS_SLOTCTL_SRC_LSB = 0;
  localparam int unsigned VIRS_SLOTCTL_EN_BIT = 5;

  // Privileged-mode flag within pprot, and the guard enable bit.
  localparam int unsigned VIRS_PPROT_PRIV_BIT = 0;
  localparam int unsigned VIRS_GUARD_EN_BIT = 0;

  // Event status and mask bit positions.
  localparam int unsigned VIRS_EVT_PRIV_REFUSED = 0;
  localparam int unsigned VIRS_EVT_UNMAPPED = 1;

  localparam logic [31:0] VIRS_RESET_WORD = 32'h00000000;

endpackage

// file: verification/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import virs_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, hw_request = 32'h0, prdata, rd, v, c;
  logic [3:0] pstrb = 4'hF;
  logic [2:0] pprot = 3'h1;
  logic pready, pslverr, irq_out, irq_vectored, event_irq, irq_taken, err;
  int error_cnt = 0, n_checks = 0, cyc = 0;
  integer seed = 22;
  virs_vectored_irq dut_u (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .pprot(pprot),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .hw_request(hw_request),
    .irq_out(irq_out),
    .irq_vectored(irq_vectored),
    .event_irq(event_irq)
  );
  virs_core_model #(.TAKE_LAT(3)) core_u (.pclk(pclk), .presetn(presetn),
    .irq_line(irq_out), .irq_taken(irq_taken));
  initial forever #2 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Expected values come from the rules alone, never from the design.
  function automatic logic [31:0] clr_exp(input logic [31:0] cur, input logic [31:0] ones);
    return cur & ~ones;
  endfunction
  function automatic logic [31:0] irq_exp(input logic [31:0] req, input logic [31:0] en);
    return {31'h0, |(req & en)};
  endfunction
  // Waits on pready itself; only the cycle ceiling ends a hung transfer.
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [2:0] p);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pprot <= p;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 3'h1);
  endtask
  task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 3'h1);
    chk(what, exp, rd);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("enable_clear", VIRS_ADDR_ENABLE_CLEAR, 32'h0);
    rdchk("software_request", VIRS_ADDR_SOFTWARE_REQUEST, 32'h0);
    rdchk("software_request_clear", VIRS_ADDR_SOFTWARE_REQUEST_CLEAR, 32'h0);
    rdchk("privilege_guard", VIRS_ADDR_PRIVILEGE_GUARD, 32'h0);
    $display("Test reset values done");
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      rd = $random(seed);
      c = 32'h1 << rd[4:0];
      wr(VIRS_ADDR_ENABLE_CLEAR, 32'hFFFFFFFF);
      wr(VIRS_ADDR_REQUEST_ENABLE, v);
      if (i[0]) hw_request <= c;
      else wr(VIRS_ADDR_SOFTWARE_REQUEST, c);
      repeat (3) @(posedge pclk);
      chk("irq_out", irq_exp(c, v), 32'(irq_out));
      hw_request <= 32'h0;
      wr(VIRS_ADDR_SOFTWARE_REQUEST, 32'h0);
    end
    $display("Test request merge done");
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      c = (i == 0) ? 32'h0 : $random(seed);
      wr(VIRS_ADDR_SOFTWARE_REQUEST, v);
      wr(VIRS_ADDR_SOFTWARE_REQUEST_CLEAR, c);
      rdchk("software_request", VIRS_ADDR_SOFTWARE_REQUEST, clr_exp(v, c));
      wr(VIRS_ADDR_ENABLE_CLEAR, 32'hFFFFFFFF);
      wr(VIRS_ADDR_REQUEST_ENABLE, v);
      wr(VIRS_ADDR_ENABLE_CLEAR, c);
      rdchk("request_enable", VIRS_ADDR_REQUEST_ENABLE, clr_exp(v, c));
    end
    wr(VIRS_ADDR_ENABLE_CLEAR, 32'hFFFFFFFF);
    wr(VIRS_ADDR_SOFTWARE_REQUEST, 32'h0);
    $display("Test clear registers done");
    v = $random(seed);
    wr(VIRS_ADDR_DEFAULT_VECTOR, v);
    rdchk("current_vector", VIRS_ADDR_CURRENT_VECTOR, v);
    for (int i = 0; i < 16; i++) begin
      c = $random(seed);
      wr(VIRS_ADDR_SLOT_VECTOR_BASE + 32'(4 * i), c);
      rdchk("slot_vector", VIRS_ADDR_SLOT_VECTOR_BASE + 32'(4 * i), c);
    end
    // Highest slot and highest source, so an off-by-one in either index shows.
    wr(VIRS_ADDR_SLOT_CONTROL_BASE + 32'h3C, 32'h3F);
    wr(VIRS_ADDR_REQUEST_ENABLE, 32'h80000000);
    hw_request <= 32'h80000000;
    for (int n = 0; n < 20 && irq_taken !== 1'b1; n++) @(posedge pclk);
    chk("irq_taken", 32'h1, 32'(irq_taken));
    chk("irq_vectored", 32'h1, 32'(irq_vectored));
    rdchk("current_vector", VIRS_ADDR_CURRENT_VECTOR, c);
    hw_request <= 32'h0;
    $display("Test vectors done");
    wr(VIRS_ADDR_EVENT_MASK, 32'h3);
    wr(VIRS_ADDR_PRIVILEGE_GUARD, 32'h1);
    v = $random(seed);
    wr(VIRS_ADDR_SOFTWARE_REQUEST, v);
    apb(1'b1, VIRS_ADDR_SOFTWARE_REQUEST, ~v, 3'h0);
    chk("user write refused", 32'h1, 32'(err));
    apb(1'b0, VIRS_ADDR_SOFTWARE_REQUEST, 32'h0, 3'h0);
    chk("user read data", 32'h0, rd);
    apb(1'b1, VIRS_ADDR_PRIVILEGE_GUARD, 32'h0, 3'h0);
    rdchk("software_request", VIRS_ADDR_SOFTWARE_REQUEST, v);
    chk("event_irq", 32'h1, 32'(event_irq));
    rdchk("event_status", VIRS_ADDR_EVENT_STATUS, 32'h1);
    wr(VIRS_ADDR_EVENT_STATUS, 32'h1);
    repeat (2) @(posedge pclk);
    chk("event_irq", 32'h0, 32'(event_irq));
    wr(VIRS_ADDR_PRIVILEGE_GUARD, 32'h0);
    apb(1'b0, VIRS_ADDR_SOFTWARE_REQUEST, 32'h0, 3'h0);
    chk("user read open", v, rd);
    apb(1'b0, 32'hFFFFF024, 32'h0, 3'h1);
    chk("unmapped error", 32'h1, 32'(err));
    rdchk("event_status", VIRS_ADDR_EVENT_STATUS, 32'h2);
    wr(VIRS_ADDR_EVENT_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk("masked event_irq", 32'h0, 32'(event_irq));
    $display("Test guard and events done");
    wrap_up();
  end
endmodule
bind virs_vectored_irq virs_checker chk_u (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pstrb(pstrb),
  .pprot(pprot),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .hw_request(hw_request),
  .irq_out(irq_out),
  .irq_vectored(irq_vectored),
  .event_irq(event_irq)
);
`default_nettype wire

// file: verification/virs_core_model.sv
`timescale 1ns/1ns
`default_nettype none
// The core finishes its current instruction before entering the handler.
module virs_core_model #(
  parameter int TAKE_LAT = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic irq_line,
  output logic irq_taken
);
  int wait_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= 0;
      irq_taken <= 1'b0;
    end else if (!irq_line) begin
      wait_cnt <= 0;
      irq_taken <= 1'b0;
    end else if (wait_cnt < TAKE_LAT) begin
      wait_cnt <= wait_cnt + 1;
    end else begin
      irq_taken <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: verification/virs_properties.sv
`timescale 1ns/1ns
`default_nettype none
module virs_checker
  import virs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [2:0] pprot,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] hw_request,
  input wire logic irq_out,
  input wire logic irq_vectored,
  input wire logic event_irq
);
  // Shadows assume full-word strobes, which is all the bench ever issues.
  logic [31:0] en_sh, sw_sh, dv_sh;
  logic grd_sh, slot_on;
  wire logic wr = psel && penable && pready && pwrite && !pslverr;
  wire logic setup = psel && !penable;
  wire logic ok = pprot[0] || !grd_sh;
  wire logic cause = |((hw_request | sw_sh) & en_sh);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_sh <= 32'h0;
      sw_sh <= 32'h0;
      dv_sh <= 32'h0;
      grd_sh <= 1'b0;
      slot_on <= 1'b0;
    end else if (wr) begin
      case (paddr)
        VIRS_ADDR_REQUEST_ENABLE: en_sh <= en_sh | pwdata;
        VIRS_ADDR_ENABLE_CLEAR: en_sh <= en_sh & ~pwdata;
        VIRS_ADDR_SOFTWARE_REQUEST: sw_sh <= pwdata;
        VIRS_ADDR_SOFTWARE_REQUEST_CLEAR: sw_sh <= sw_sh & ~pwdata;
        VIRS_ADDR_PRIVILEGE_GUARD: grd_sh <= pwdata[0];
        VIRS_ADDR_DEFAULT_VECTOR: dv_sh <= pwdata;
        default: slot_on <= slot_on | (paddr[31:6] == VIRS_ADDR_SLOT_CONTROL_BASE[31:6] && pwdata[5]);
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_irq_level;
    irq_out == $past(cause);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq_out mismatch");
  property p_swreq_read;
    setup && !pwrite && ok && paddr == VIRS_ADDR_SOFTWARE_REQUEST |=> prdata == $past(sw_sh);
  endproperty
  a_swreq_read: assert property (p_swreq_read) else $error("sw read bad");
  property p_enable_read;
    setup && !pwrite && ok && paddr == VIRS_ADDR_REQUEST_ENABLE |=> prdata == $past(en_sh);
  endproperty
  a_enable_read: assert property (p_enable_read) else $error("enable read bad");
  property p_guard_refuse;
    setup && grd_sh && !pprot[0] |=> pready && pslverr && prdata == 32'h0;
  endproperty
  a_guard_refuse: assert property (p_guard_refuse) else $error("not refused");
  property p_guard_allow;
    setup && pprot[0] && paddr == VIRS_ADDR_SOFTWARE_REQUEST |=> pready && !pslverr;
  endproperty
  a_guard_allow: assert property (p_guard_allow) else $error("wrongly refused");
  property p_default_vec;
    setup && !pwrite && ok && !slot_on && paddr == VIRS_ADDR_CURRENT_VECTOR
      |=> prdata == $past(dv_sh);
  endproperty
  a_default_vec: assert property (p_default_vec) else $error("vector bad");
  property p_no_slot;
    !slot_on |-> !irq_vectored;
  endproperty
  a_no_slot: assert property (p_no_slot) else $error("vectored without slot");
  property p_ready_once;
    pready |-> $past(psel && !penable);
  endproperty
  a_ready_once: assert property (p_ready_once) else $error("pready without setup");
  property p_unmapped;
    setup && paddr == 32'hFFFFF024 |=> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped accepted");
endmodule
`default_nettype wire

// file: verilog/virs_slot_select.sv
`timescale 1ns/1ns
`default_nettype none

// Picks the handler address for the normal interrupt: the lowest-numbered
// enabled slot whose source is active wins, otherwise the default address.
module virs_slot_select
  import virs_pkg::*;
(
  input wire logic [virs_pkg::VIRS_NSRC-1:0] active_src,
  input wire logic [virs_pkg::VIRS_NSLOT-1:0] slot_en,
  input wire logic [virs_pkg::VIRS_NSLOT*virs_pkg::VIRS_SRC_W-1:0] slot_src,
  input wire logic [virs_pkg::VIRS_NSLOT*virs_pkg::VIRS_DW-1:0] slot_vec,
  input wire logic [virs_pkg::VIRS_DW-1:0] default_vector,
  output logic slot_hit,
  output logic [virs_pkg::VIRS_DW-1:0] vector
);

  logic [VIRS_NSLOT-1:0] slot_match;

  ////////////////////////////////////////////////////////////////////////////
  for (genvar s = 0; s < VIRS_NSLOT; s++) begin : g_match
    assign slot_match[s] = slot_en[s] &
        active_src[slot_src[s*VIRS_SRC_W +: VIRS_SRC_W]];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Walk downward so the lowest matching slot overwrites the others.
  always_comb begin
    slot_hit = 1'b0;
    vector = default_vector;
    for (int s = VIRS_NSLOT - 1; s >= 0; s--) begin
      if (slot_match[s]) begin
        slot_hit = 1'b1;
        vector = slot_vec[s*VIRS_DW +: VIRS_DW];
      end
    end
  end

endmodule

`default_nettype wire

// file: verilog/virs_vectored_irq.sv
// Function
// - Software requests ORed into 32 hardware requests.
// - Software request clear drops written-one bits.
// - Enable clear drops written-one enable bits.
// - Guard set: only privileged accesses accepted.
// - Current vector read returns handler address.
// - Default address serves unassigned normal interrupts.
// - Sixteen slots, each with handler address.
// - Only enabled sources reach interrupt outputs.
//
// The APB slave port was decided locally.
`timescale 1ns/1ns
`default_nettype none

module virs_vectored_irq
  import virs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [virs_pkg::VIRS_AW-1:0] paddr,
  input wire logic [virs_pkg::VIRS_DW-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [2:0] pprot,
  output logic [virs_pkg::VIRS_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [virs_pkg::VIRS_NSRC-1:0] hw_request,
  output logic irq_out,
  output logic irq_vectored,
  output logic event_irq
);

  import virs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register state.

  logic [VIRS_NSRC-1:0] request_enable_reg, request_enable_next;
  logic [VIRS_NSRC-1:0] software_request_reg, software_request_next;
  logic privilege_guard_reg, privilege_guard_next;
  logic [VIRS_DW-1:0] default_vector_reg, default_vector_next;
  logic [VIRS_NEVT-1:0] event_status_reg, event_status_next;
  logic [VIRS_NEVT-1:0] event_mask_reg, event_mask_next;
  logic [VIRS_DW-1:0] slot_vector_reg [VIRS_NSLOT];
  logic [VIRS_SRC_W-1:0] slot_source_reg [VIRS_NSLOT];
  logic [VIRS_NSLOT-1:0] slot_enable_reg;

  logic [VIRS_DW-1:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic irq_out_reg, irq_out_next;
  logic irq_vectored_reg, irq_vectored_next;
  logic event_irq_reg, event_irq_next;

  ////////////////////////////////////////////////////////////////////////////
  // Request combination and vector selection.

  logic [VIRS_NSRC-1:0] merged_request;
  logic [VIRS_NSRC-1:0] active_src;
  logic [VIRS_NSLOT*VIRS_SRC_W-1:0] slot_src_flat;
  logic [VIRS_NSLOT*VIRS_DW-1:0] slot_vec_flat;
  logic slot_hit;
  logic [VIRS_DW-1:0] sel_vector;

  // Software requests look exactly like peripheral requests from here on.
  assign merged_request = hw_request | software_request_reg;
  assign active_src = merged_request & request_enable_reg;

  for (genvar s = 0; s < VIRS_NSLOT; s++) begin : g_flat
    assign slot_src_flat[s*VIRS_SRC_W +: VIRS_SRC_W] = slot_source_reg[s];
    assign slot_vec_flat[s*VIRS_DW +: VIRS_DW] = slot_vector_reg[s];
  end

  virs_slot_select u_select (
    .active_src(active_src),
    .slot_en(slot_enable_reg),
    .slot_src(slot_src_flat),
    .slot_vec(slot_vec_flat),
    .default_vector(default_vector_reg),
    .slot_hit(slot_hit),
    .vector(sel_vector)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  logic setup_phase;
  logic wr_commit;
  logic priv_ok;
  logic hit_enable, hit_enclr, hit_swreq, hit_swclr, hit_guard;
  logic hit_curvec, hit_defvec, hit_evstat, hit_evmask;
  logic hit_slotvec, hit_slotctl;
  logic mapped;
  logic [VIRS_SLOT_W-1:0] slot_idx;
  logic [VIRS_DW-1:0] wmask;

  assign setup_phase = psel & ~penable;
  // The access-phase edge with pready high is the only one that commits.
  assign wr_commit = psel & penable & pready_reg & pwrite & ~pslverr_reg;

  // With the guard clear any access is taken; with it set only privileged ones.
  assign priv_ok = ~privilege_guard_reg | pprot[VIRS_PPROT_PRIV_BIT];

  assign hit_enable = (paddr == VIRS_ADDR_REQUEST_ENABLE);
  assign hit_enclr = (paddr == VIRS_ADDR_ENABLE_CLEAR);
  assign hit_swreq = (paddr == VIRS_ADDR_SOFTWARE_REQUEST);
  assign hit_swclr = (paddr == VIRS_ADDR_SOFTWARE_REQUEST_CLEAR);
  assign hit_guard = (paddr == VIRS_ADDR_PRIVILEGE_GUARD);
  assign hit_curvec = (paddr == VIRS_ADDR_CURRENT_VECTOR);
  assign hit_defvec = (paddr == VIRS_ADDR_DEFAULT_VECTOR);
  assign hit_evstat = (paddr == VIRS_ADDR_EVENT_STATUS);
  assign hit_evmask = (paddr == VIRS_ADDR_EVENT_MASK);
  assign hit_slotvec = (paddr[VIRS_AW-1:VIRS_SLOT_REGION_LSB] ==
      VIRS_ADDR_SLOT_VECTOR_BASE[VIRS_AW-1:VIRS_SLOT_REGION_LSB]) &
      (paddr[VIRS_SLOT_IDX_LSB-1:0] == VIRS_RESET_WORD[VIRS_SLOT_IDX_LSB-1:0]);
  assign hit_slotctl = (paddr[VIRS_AW-1:VIRS_SLOT_REGION_LSB] ==
      VIRS_ADDR_SLOT_CONTROL_BASE[VIRS_AW-1:VIRS_SLOT_REGION_LSB]) &
      (paddr[VIRS_SLOT_IDX_LSB-1:0] == VIRS_RESET_WORD[VIRS_SLOT_IDX_LSB-1:0]);
  assign slot_idx = paddr[VIRS_SLOT_IDX_LSB +: VIRS_SLOT_W];
  assign mapped = hit_enable | hit_enclr | hit_swreq | hit_swclr | hit_guard |
      hit_curvec | hit_defvec | hit_evstat | hit_evmask | hit_slotvec | hit_slotctl;

  // Byte strobes widen into a bit mask for the word-wide registers; single-byte fields use pstrb[0] alone.
  for (genvar b = 0; b < 4; b++) begin : g_wmask
    assign wmask[b*8 +: 8] = {8{pstrb[b]}};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer: one wait-free access phase, data and error captured at setup.

  always_comb begin
    prdata_next = VIRS_RESET_WORD;
    pready_next = setup_phase;
    pslverr_next = 1'b0;
    if (setup_phase) begin
      if (!mapped || !priv_ok) begin
        pslverr_next = 1'b1;
      end else if (!pwrite) begin
        // Write-only clear registers and unused bits read back as zero.
        if (hit_enable) begin
          prdata_next = request_enable_reg;
        end else if (hit_swreq) begin
          prdata_next = software_request_reg;
        end else if (hit_guard) begin
          prdata_next[VIRS_GUARD_EN_BIT] = privilege_guard_reg;
        end else if (hit_curvec) begin
          prdata_next = sel_vector;
        end else if (hit_defvec) begin
          prdata_next = default_vector_reg;
        end else if (hit_evstat) begin
          prdata_next[VIRS_NEVT-1:0] = event_status_reg;
        end else if (hit_evmask) begin
          prdata_next[VIRS_NEVT-1:0] = event_mask_reg;
        end else if (hit_slotvec) begin
          prdata_next = slot_vector_reg[slot_idx];
        end else if (hit_slotctl) begin
          prdata_next[VIRS_SLOTCTL_SRC_LSB +: VIRS_SRC_W] = slot_source_reg[slot_idx];
          prdata_next[VIRS_SLOTCTL_EN_BIT] = slot_enable_reg[slot_idx];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= VIRS_RESET_WORD;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Control registers.

  always_comb begin
    request_enable_next = request_enable_reg;
    software_request_next = software_request_reg;
    privilege_guard_next = privilege_guard_reg;
    default_vector_next = default_vector_reg;
    event_mask_next = event_mask_reg;
    if (wr_commit) begin
      // Writing ones to the enable register adds sources; zeros leave them.
      if (hit_enable) begin
        request_enable_next = request_enable_reg | (pwdata & wmask);
      end
      if (hit_enclr) begin
        request_enable_next = request_enable_reg & ~(pwdata & wmask);
      end
      if (hit_swreq) begin
        software_request_next = (software_request_reg & ~wmask) | (pwdata & wmask);
      end
      if (hit_swclr) begin
        software_request_next = software_request_reg & ~(pwdata & wmask);
      end
      if (hit_guard && pstrb[0]) begin
        privilege_guard_next = pwdata[VIRS_GUARD_EN_BIT];
      end
      if (hit_defvec) begin
        default_vector_next = (default_vector_reg & ~wmask) | (pwdata & wmask);
      end
      if (hit_evmask && pstrb[0]) begin
        event_mask_next = pwdata[VIRS_NEVT-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      request_enable_reg <= VIRS_RESET_WORD;
      software_request_reg <= VIRS_RESET_WORD;
      privilege_guard_reg <= 1'b0;
      default_vector_reg <= VIRS_RESET_WORD;
      event_mask_reg <= '0;
    end else begin
      request_enable_reg <= request_enable_next;
      software_request_reg <= software_request_next;
      privilege_guard_reg <= privilege_guard_next;
      default_vector_reg <= default_vector_next;
      event_mask_reg <= event_mask_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slot registers, one handler address and one control word per slot.

  for (genvar s = 0; s < VIRS_NSLOT; s++) begin : g_slot
    logic [VIRS_DW-1:0] vec_next;
    logic [VIRS_SRC_W-1:0] src_next;
    logic en_next;
    logic sel_here;

    assign sel_here = wr_commit & (slot_idx == VIRS_SLOT_W'(s));

    always_comb begin
      vec_next = slot_vector_reg[s];
      src_next = slot_source_reg[s];
      en_next = slot_enable_reg[s];
      if (sel_here && hit_slotvec) begin
        vec_next = (slot_vector_reg[s] & ~wmask) | (pwdata & wmask);
      end
      if (sel_here && hit_slotctl && pstrb[0]) begin
        src_next = pwdata[VIRS_SLOTCTL_SRC_LSB +: VIRS_SRC_W];
        en_next = pwdata[VIRS_SLOTCTL_EN_BIT];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        slot_vector_reg[s] <= VIRS_RESET_WORD;
        slot_source_reg[s] <= '0;
        slot_enable_reg[s] <= 1'b0;
      end else begin
        slot_vector_reg[s] <= vec_next;
        slot_source_reg[s] <= src_next;
        slot_enable_reg[s] <= en_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event status: refused and unmapped accesses. A new event beats a
  // same-cycle write-one-to-clear so that no event is ever lost.

  logic [VIRS_NEVT-1:0] event_set;
  logic [VIRS_NEVT-1:0] event_clr;

  always_comb begin
    event_set = '0;
    event_set[VIRS_EVT_PRIV_REFUSED] = setup_phase & mapped & ~priv_ok;
    event_set[VIRS_EVT_UNMAPPED] = setup_phase & ~mapped;
    event_clr = '0;
    if (wr_commit && hit_evstat && pstrb[0]) begin
      event_clr = pwdata[VIRS_NEVT-1:0];
    end
    event_status_next = (event_status_reg & ~event_clr) | event_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_status_reg <= '0;
    end else begin
      event_status_reg <= event_status_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs to the core. Registering them costs one cycle of interrupt
  // latency but keeps every output glitch-free.

  always_comb begin
    irq_out_next = |active_src;
    irq_vectored_next = slot_hit;
    event_irq_next = |(event_status_reg & event_mask_reg);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_out_reg <= 1'b0;
      irq_vectored_reg <= 1'b0;
      event_irq_reg <= 1'b0;
    end else begin
      irq_out_reg <= irq_out_next;
      irq_vectored_reg <= irq_vectored_next;
      event_irq_reg <= event_irq_next;
    end
  end

  assign irq_out = irq_out_reg;
  assign irq_vectored = irq_vectored_reg;
  assign event_irq = event_irq_reg;

endmodule

`default_nettype wire
